/* File: adrtc_consts.vh */
`ifndef ADRTC_CONSTS_VH
`define ADRTC_CONSTS_VH

// Register indices; byte address is four times the index
`define ADRTC_IDX_RES_LO    10'h004
`define ADRTC_IDX_RES_HI    10'h005
`define ADRTC_IDX_CTRL      10'h006
`define ADRTC_IDX_MUX       10'h007
`define ADRTC_IDX_TRIG      10'h08E
`define ADRTC_IDX_IRQ_STAT  10'h020
`define ADRTC_IDX_IRQ_MASK  10'h021

// Control register fields
`define ADRTC_CTRL_EN       7
`define ADRTC_CTRL_START    6
`define ADRTC_CTRL_AUTO     5
`define ADRTC_CTRL_FLAG     4
`define ADRTC_CTRL_IE       3

// Mux register fields
`define ADRTC_MUX_LJ        5

// Reset values
`define ADRTC_RST_BYTE      8'h00
`define ADRTC_RST_RESULT    10'h000

// Conversion lengths in converter clock cycles
`define ADRTC_CONV_NORMAL   5'h0D
`define ADRTC_CONV_FIRST    5'h19

// Differential channel codes span this range of the channel select
`define ADRTC_DIFF_LO       5'h08
`define ADRTC_DIFF_HI       5'h1D

// AXI responses
`define ADRTC_RESP_OKAY     2'h0
`define ADRTC_RESP_SLVERR   2'h2

`endif

/* File: adrtc_prescaler.v */
`timescale 1ns/10ps
`default_nettype none
module adrtc_prescaler #(
   parameter CW = 7
) (
   // Clock and reset
   input  wire         aclk,
   input  wire         aresetn,
   // Divider control
   input  wire [2:0]   clock_divider_select,
   output reg          tick_r
);
   reg [CW-1:0] cnt_r;
   reg [CW-1:0] limit;

   // Codes 0 and 1 both divide by two
   always @*
   begin
      case (clock_divider_select)
         3'h0, 3'h1: limit = 7'h01;
         3'h2:       limit = 7'h03;
         3'h3:       limit = 7'h07;
         3'h4:       limit = 7'h0F;
         3'h5:       limit = 7'h1F;
         3'h6:       limit = 7'h3F;
         default:    limit = 7'h7F;
      endcase
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cnt_r  <= {CW{1'b0}};
         tick_r <= 1'b0;
      end
      else if (cnt_r >= limit)
      begin
         cnt_r  <= {CW{1'b0}};
         tick_r <= 1'b1;
      end
      else
      begin
         cnt_r  <= cnt_r + 7'h01;
         tick_r <= 1'b0;
      end
   end
endmodule // adrtc_prescaler
`default_nettype wire

/* File: adrtc_trig_edge.v */
`timescale 1ns/10ps
`default_nettype none
module adrtc_trig_edge (
   // Clock and reset
   input  wire         aclk,
   input  wire         aresetn,
   // Flags and selection
   input  wire [7:1]   trig_flags,
   input  wire [2:0]   trigger_source,
   output wire         rise
);
   reg  prev_r;
   // Free running contributes a constant low, so selecting it never makes an edge
   wire sel = (trigger_source == 3'h0) ? 1'b0 : trig_flags[trigger_source];

   // Compare with last cycle's selected value, so a source switch can be an edge
   always @(posedge aclk)
   begin
      if (!aresetn)
         prev_r <= 1'b0;
      else
         prev_r <= sel;
   end

   assign rise = sel & ~prev_r;
endmodule // adrtc_trig_edge
`default_nettype wire

/* File: adrtc_top.v */
`timescale 1ns/10ps
`default_nettype none
`include "adrtc_consts.vh"
module adrtc_top #(
   parameter AW = 12
) (
   // Clock and reset
   input  wire          aclk,
   input  wire          aresetn,
   // AXI4-Lite write address
   input  wire [AW-1:0] s_axi_awaddr,
   input  wire          s_axi_awvalid,
   output reg           s_axi_awready,
   // AXI4-Lite write data
   input  wire [31:0]   s_axi_wdata,
   input  wire [3:0]    s_axi_wstrb,
   input  wire          s_axi_wvalid,
   output reg           s_axi_wready,
   // AXI4-Lite write response
   output reg  [1:0]    s_axi_bresp,
   output reg           s_axi_bvalid,
   input  wire          s_axi_bready,
   // AXI4-Lite read
   input  wire [AW-1:0] s_axi_araddr,
   input  wire          s_axi_arvalid,
   output reg           s_axi_arready,
   output reg  [31:0]   s_axi_rdata,
   output reg  [1:0]    s_axi_rresp,
   output reg           s_axi_rvalid,
   input  wire          s_axi_rready,
   // Processor side
   input  wire          global_irq_enable,
   input  wire          irq_ack,
   output reg           irq,
   // Trigger flags from comparator, external interrupt and timers
   input  wire [7:1]    trig_flags,
   // Analog core
   input  wire [9:0]    analog_result,
   output reg           sample_start,
   output reg  [4:0]    channel_select_out,
   output reg           converter_on
);
   // Register state
   reg        converter_enable_r;
   reg        auto_trigger_enable_r;
   reg        completion_flag_r;
   reg        completion_irq_enable_r;
   reg [2:0]  clock_divider_select_r;
   reg        left_justify_r;
   reg [4:0]  channel_select_r;
   reg [1:0]  refsel_r;
   reg [2:0]  trigger_source_r;
   reg        irq_mask_r;
   reg [9:0]  result_r;
   reg        read_lock_r;
   // Conversion state
   localparam ST_IDLE = 1'b0;
   localparam ST_CONV = 1'b1;
   reg        state_r;
   reg [4:0]  cnt_r;
   reg [4:0]  conv_len_r;
   reg        first_r;
   reg        diff_r;
   // Bus state
   reg          aw_held_r;
   reg          w_held_r;
   reg [AW-1:0] awaddr_r;
   reg [7:0]    wdata_r;
   reg          wstrb0_r;

   wire tick;
   wire trig_rise;

   adrtc_prescaler #(.CW(7)) u_presc (
      .aclk                 (aclk),
      .aresetn              (aresetn),
      .clock_divider_select (clock_divider_select_r),
      .tick_r               (tick)
   );

   adrtc_trig_edge u_edge (
      .aclk           (aclk),
      .aresetn        (aresetn),
      .trig_flags     (trig_flags),
      .trigger_source (trigger_source_r),
      .rise           (trig_rise)
   );

   // Bus decode
   wire [9:0] widx   = awaddr_r[11:2];
   wire [9:0] ridx   = s_axi_araddr[11:2];
   wire       wr_go  = aw_held_r & w_held_r & ~s_axi_bvalid;
   wire       wr_en  = wr_go & wstrb0_r;
   wire       rd_go  = s_axi_arvalid & s_axi_arready;
   wire       busy   = (state_r == ST_CONV);

   wire wr_ctrl  = wr_en & (widx == `ADRTC_IDX_CTRL);
   wire wr_mux   = wr_en & (widx == `ADRTC_IDX_MUX);
   wire wr_trig  = wr_en & (widx == `ADRTC_IDX_TRIG);
   wire wr_stat  = wr_en & (widx == `ADRTC_IDX_IRQ_STAT);
   wire wr_mask  = wr_en & (widx == `ADRTC_IDX_IRQ_MASK);

   wire w_map = (widx == `ADRTC_IDX_CTRL) | (widx == `ADRTC_IDX_MUX) |
                (widx == `ADRTC_IDX_TRIG) | (widx == `ADRTC_IDX_IRQ_STAT) |
                (widx == `ADRTC_IDX_IRQ_MASK) | (widx == `ADRTC_IDX_RES_LO) |
                (widx == `ADRTC_IDX_RES_HI);

   // Result presentation follows the justification bit combinationally
   wire [7:0] res_lo = left_justify_r ? {result_r[1:0], 6'h00}
                                      : result_r[7:0];
   wire [7:0] res_hi = left_justify_r ? result_r[9:2]
                                      : {6'h00, result_r[9:8]};
   wire [7:0] ctrl_rd = {converter_enable_r, busy, auto_trigger_enable_r,
                         completion_flag_r, completion_irq_enable_r,
                         clock_divider_select_r};

   reg [7:0] rd_byte;
   reg       rd_ok;
   always @*
   begin
      rd_ok   = 1'b1;
      rd_byte = 8'h00;
      case (ridx)
         `ADRTC_IDX_RES_LO:   rd_byte = res_lo;
         `ADRTC_IDX_RES_HI:   rd_byte = res_hi;
         `ADRTC_IDX_CTRL:     rd_byte = ctrl_rd;
         `ADRTC_IDX_MUX:      rd_byte = {refsel_r, left_justify_r, channel_select_r};
         `ADRTC_IDX_TRIG:     rd_byte = {5'h00, trigger_source_r};
         `ADRTC_IDX_IRQ_STAT: rd_byte = {7'h00, completion_flag_r};
         `ADRTC_IDX_IRQ_MASK: rd_byte = {7'h00, irq_mask_r};
         default:             rd_ok   = 1'b0;
      endcase
   end

   // Start sources; writes of zero to the start bit do nothing
   wire sw_start   = wr_ctrl & wdata_r[`ADRTC_CTRL_START];
   wire en_nxt     = wr_ctrl ? wdata_r[`ADRTC_CTRL_EN] : converter_enable_r;
   wire auto_start = auto_trigger_enable_r & trig_rise;
   wire conv_done  = busy & tick & (cnt_r == conv_len_r - 5'h01);
   wire free_run   = auto_trigger_enable_r & (trigger_source_r == 3'h0) & conv_done;
   wire start_req  = en_nxt & (sw_start | auto_start | free_run);
   wire is_diff    = (channel_select_r >= `ADRTC_DIFF_LO) &
                     (channel_select_r <= `ADRTC_DIFF_HI);

   // Conversion engine
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_r      <= ST_IDLE;
         cnt_r        <= 5'h00;
         conv_len_r   <= `ADRTC_CONV_NORMAL;
         first_r      <= 1'b1;
         diff_r       <= 1'b0;
         sample_start <= 1'b0;
      end
      else
      begin
         sample_start <= 1'b0;
         if (!en_nxt)
         begin
            // Turning off aborts any conversion and rearms the long first one
            state_r <= ST_IDLE;
            first_r <= 1'b1;
         end
         else if (start_req & (~busy | conv_done))
         begin
            state_r      <= ST_CONV;
            cnt_r        <= 5'h00;
            conv_len_r   <= first_r ? `ADRTC_CONV_FIRST : `ADRTC_CONV_NORMAL;
            first_r      <= 1'b0;
            diff_r       <= is_diff;
            sample_start <= 1'b1;
         end
         else if (conv_done)
            state_r <= ST_IDLE;
         else if (busy & tick)
            cnt_r <= cnt_r + 5'h01;
      end
   end

   // Result capture and read lock
   wire rd_lo = rd_go & (ridx == `ADRTC_IDX_RES_LO);
   wire rd_hi = rd_go & (ridx == `ADRTC_IDX_RES_HI);
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         result_r    <= `ADRTC_RST_RESULT;
         read_lock_r <= 1'b0;
      end
      else
      begin
         // A result finishing while locked is dropped, keeping the byte pair coherent
         if (conv_done & ~read_lock_r)
            result_r <= diff_r ? {~analog_result[9], analog_result[8:0]}
                               : analog_result;
         if (rd_hi)
            read_lock_r <= 1'b0;
         else if (rd_lo)
            read_lock_r <= 1'b1;
      end
   end

   // Software registers; hardware set of the flag wins over any clear
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         converter_enable_r      <= 1'b0;
         auto_trigger_enable_r   <= 1'b0;
         completion_flag_r       <= 1'b0;
         completion_irq_enable_r <= 1'b0;
         clock_divider_select_r  <= 3'h0;
         left_justify_r          <= 1'b0;
         channel_select_r        <= 5'h00;
         refsel_r                <= 2'h0;
         trigger_source_r        <= 3'h0;
         irq_mask_r              <= 1'b0;
      end
      else
      begin
         if (wr_ctrl)
         begin
            converter_enable_r      <= wdata_r[`ADRTC_CTRL_EN];
            auto_trigger_enable_r   <= wdata_r[`ADRTC_CTRL_AUTO];
            completion_irq_enable_r <= wdata_r[`ADRTC_CTRL_IE];
            clock_divider_select_r  <= wdata_r[2:0];
         end
         if (wr_mux)
         begin
            refsel_r         <= wdata_r[7:6];
            left_justify_r   <= wdata_r[`ADRTC_MUX_LJ];
            channel_select_r <= wdata_r[4:0];
         end
         if (wr_trig)
            trigger_source_r <= wdata_r[2:0];
         if (wr_mask)
            irq_mask_r <= wdata_r[0];
         if (conv_done)
            completion_flag_r <= 1'b1;
         else if (irq_ack | (wr_ctrl & wdata_r[`ADRTC_CTRL_FLAG]) | (wr_stat & wdata_r[0]))
            completion_flag_r <= 1'b0;
      end
   end

   // Outputs
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         irq                <= 1'b0;
         channel_select_out <= 5'h00;
         converter_on       <= 1'b0;
      end
      else
      begin
         irq <= completion_flag_r & irq_mask_r & completion_irq_enable_r
                & global_irq_enable;
         channel_select_out <= channel_select_r;
         converter_on       <= converter_enable_r;
      end
   end

   // AXI4-Lite write channels: address and data held independently, answered together
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `ADRTC_RESP_OKAY;
         aw_held_r     <= 1'b0;
         w_held_r      <= 1'b0;
         awaddr_r      <= {AW{1'b0}};
         wdata_r       <= `ADRTC_RST_BYTE;
         wstrb0_r      <= 1'b0;
      end
      else
      begin
         s_axi_awready <= ~aw_held_r & ~(s_axi_awvalid & s_axi_awready) & ~s_axi_bvalid;
         s_axi_wready  <= ~w_held_r & ~(s_axi_wvalid & s_axi_wready) & ~s_axi_bvalid;
         if (s_axi_awvalid & s_axi_awready)
         begin
            aw_held_r <= 1'b1;
            awaddr_r  <= s_axi_awaddr;
         end
         if (s_axi_wvalid & s_axi_wready)
         begin
            w_held_r <= 1'b1;
            wdata_r  <= s_axi_wdata[7:0];
            wstrb0_r <= s_axi_wstrb[0];
         end
         if (wr_go)
         begin
            aw_held_r    <= 1'b0;
            w_held_r     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= w_map ? `ADRTC_RESP_OKAY : `ADRTC_RESP_SLVERR;
         end
         else if (s_axi_bvalid & s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // AXI4-Lite read channel
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `ADRTC_RESP_OKAY;
      end
      else if (rd_go)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= {24'h000000, rd_byte};
         s_axi_rresp   <= rd_ok ? `ADRTC_RESP_OKAY : `ADRTC_RESP_SLVERR;
      end
      else if (s_axi_rvalid & s_axi_rready)
      begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
      else if (~s_axi_rvalid)
         s_axi_arready <= 1'b1;
   end
endmodule // adrtc_top
`default_nettype wire

/* File: adrtc_sva.sv */
`timescale 1ns/10ps
`default_nettype none
`include "adrtc_consts.vh"
module adrtc_sva (
   // Clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // Bus handshakes
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   // Converter side
   input wire logic        global_irq_enable,
   input wire logic        irq_ack,
   input wire logic        irq,
   input wire logic        sample_start,
   input wire logic        converter_on
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   AST_IRQ_GATED: assert property (irq && $past(aresetn) |-> $past(global_irq_enable))
      else $error("irq raised without global enable");
   AST_IRQ_ACK: assert property (irq_ack |-> ##2 !irq)
      else $error("irq still up after vector ack");
   AST_START_GAP: assert property (sample_start |=> (!sample_start) [*8])
      else $error("conversion starts too close");
   AST_START_ON: assert property (sample_start |=> converter_on)
      else $error("start while converter off");
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while data pending");
   AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   AST_BRESP: assert property (s_axi_bvalid |-> s_axi_bresp inside {`ADRTC_RESP_OKAY, `ADRTC_RESP_SLVERR})
      else $error("illegal write response");
   AST_RESET_QUIET: assert property ($rose(aresetn) |-> !irq && !sample_start && !s_axi_bvalid
      && !s_axi_rvalid && !converter_on)
      else $error("outputs active right after reset");
   cover property (sample_start);
   cover property (irq && irq_ack);
   cover property (s_axi_bvalid && s_axi_bresp == `ADRTC_RESP_SLVERR);
endmodule // adrtc_sva
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "adrtc_consts.vh"
module tb_top;
   localparam [11:0] A_LO = {`ADRTC_IDX_RES_LO, 2'b00};
   localparam [11:0] A_HI = {`ADRTC_IDX_RES_HI, 2'b00};
   localparam [11:0] A_CTL = {`ADRTC_IDX_CTRL, 2'b00};
   localparam [11:0] A_MUX = {`ADRTC_IDX_MUX, 2'b00};
   localparam [11:0] A_TRG = {`ADRTC_IDX_TRIG, 2'b00};
   localparam [11:0] A_ST = {`ADRTC_IDX_IRQ_STAT, 2'b00};
   localparam [11:0] A_MK = {`ADRTC_IDX_IRQ_MASK, 2'b00};
   localparam [11:0] A_BAD = 12'hFFC;
   localparam [1:0] OK = `ADRTC_RESP_OKAY;
   localparam [1:0] SE = `ADRTC_RESP_SLVERR;
   logic        aclk, aresetn, global_irq_enable, irq_ack, irq, sample_start, converter_on;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rnd, cyc, ss_cyc, nss, n0;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   logic [7:1]  trig_flags;
   logic [9:0]  analog_result, ra, rb;
   logic [4:0]  channel_select_out;
   logic [17:0] rq[$];
   logic [1:0]  bq[$];
   logic [17:0] e;
   int          err_count, n_checks, i, s;
   adrtc_top adrtc_top_i (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .global_irq_enable(global_irq_enable), .irq_ack(irq_ack), .irq(irq),
      .trig_flags(trig_flags), .analog_result(analog_result), .sample_start(sample_start),
      .channel_select_out(channel_select_out), .converter_on(converter_on));
   initial
   begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task chk(input logic [33:0] g, input logic [33:0] x);
      n_checks++;
      if (g !== x)
      begin
         err_count++;
         $display("unexpected at %0t: got %h expected %h", $time, g, x);
      end
   endtask
   task tmo;
      chk(1'b0, 1'b1);
      report_and_stop;
   endtask
   // Payload is held until its own ready edge; no cycle count is assumed
   task wr(input [11:0] a, input [7:0] d, input [1:0] r = OK);
      bq.push_back(r);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      i = 0;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         i++;
      end while (!s_axi_bvalid && i < 300);
      if (!s_axi_bvalid) tmo;
      s_axi_bready <= 1'b0;
   endtask
   task rd(input [11:0] a, input [7:0] x, input [7:0] m = 8'hFF, input [1:0] r = OK);
      rq.push_back({r, m, x});
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      i = 0;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         i++;
      end while (!s_axi_rvalid && i < 300);
      if (!s_axi_rvalid) tmo;
      s_axi_rready <= 1'b0;
   endtask
   task wirq;
      for (i = 0; i < 4000 && irq !== 1'b1; i++) @(posedge aclk);
      if (irq !== 1'b1) tmo;
   endtask
   task clr;
      wr(A_ST, 8'h01);
      repeat (2) @(posedge aclk);
      chk(irq, 1'b0);
   endtask
   // Free-running prescaler phase makes the length uncertain by up to one tick
   task conv(input [2:0] c, input int len, input [9:0] a);
      int dv, d;
      dv = (c == 3'h0) ? 2 : (1 << c);
      analog_result <= a;
      wr(A_CTL, {5'h19, c});
      wirq;
      d = cyc - ss_cyc;
      chk(d + dv >= len * dv && d <= len * dv + 4, 1'b1);
   endtask
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (sample_start)
      begin
         nss <= nss + 1;
         ss_cyc <= cyc;
      end
      if (s_axi_rvalid && s_axi_rready)
      begin
         e = rq.pop_front();
         chk({s_axi_rresp, s_axi_rdata & {24'hFFFFFF, e[15:8]}},
             {e[17:16], 24'h0, e[7:0] & e[15:8]});
      end
      if (s_axi_bvalid && s_axi_bready)
         chk(s_axi_bresp, bq.pop_front());
   end
   initial
   begin
      {aresetn, global_irq_enable, irq_ack, s_axi_awvalid, s_axi_wvalid} = 5'h00;
      {s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
      {trig_flags, analog_result} = 17'h0;
      s_axi_wstrb = 4'hF;
      {cyc, ss_cyc, nss} = 96'h0;
      rnd = 32'h2E260117;
      err_count = 0;
      n_checks = 0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      rd(A_LO, 8'h00);
      rd(A_HI, 8'h00);
      rd(A_TRG, 8'h00);
      rd(A_BAD, 8'h00, 8'hFF, SE);
      wr(A_BAD, 8'h00, SE);
      wr(A_TRG, 8'hFF);
      rd(A_TRG, 8'h07);
      $display("test 1 done");
      wr(A_MK, 8'h01);
      global_irq_enable <= 1'b1;
      for (s = 0; s < 8; s++)
      begin
         rnd = lfsr(rnd);
         ra = rnd[9:0];
         trig_flags <= rnd[16:10];
         conv(s[2:0], s == 0 ? 25 : 13, ra);
         rd(A_LO, ra[7:0]);
         rd(A_HI, {6'h00, ra[9:8]});
         clr;
      end
      wr(A_MUX, 8'h20);
      rd(A_HI, ra[9:2]);
      rd(A_LO, {ra[1:0], 6'h00});
      wr(A_MUX, 8'h00);
      rd(A_LO, ra[7:0]);
      rb = ~ra;
      conv(3'h0, 13, rb);
      rd(A_HI, {6'h00, ra[9:8]});
      rd(A_LO, ra[7:0]);
      rd(A_HI, {6'h00, ra[9:8]});
      clr;
      $display("test 2 done");
      wr(A_MUX, 8'h10);
      conv(3'h0, 13, rb);
      chk(channel_select_out, 5'h10);
      chk(converter_on, 1'b1);
      rd(A_LO, rb[7:0]);
      rd(A_HI, {6'h00, ~rb[9], rb[8]});
      global_irq_enable <= 1'b0;
      repeat (3) @(posedge aclk);
      chk(irq, 1'b0);
      global_irq_enable <= 1'b1;
      repeat (3) @(posedge aclk);
      chk(irq, 1'b1);
      irq_ack <= 1'b1;
      @(posedge aclk);
      irq_ack <= 1'b0;
      repeat (2) @(posedge aclk);
      chk(irq, 1'b0);
      wr(A_MUX, 8'h00);
      $display("test 3 done");
      trig_flags <= 7'h00;
      wr(A_CTL, 8'hA8);
      for (s = 1; s < 8; s++)
      begin
         n0 = nss;
         if (s[0])
         begin
            trig_flags <= 7'h00;
            wr(A_TRG, s[7:0]);
            trig_flags[s] <= 1'b1;
         end
         else
         begin
            trig_flags <= 7'h01 << (s - 1);
            wr(A_TRG, s[7:0]);
         end
         repeat (4) @(posedge aclk);
         rd(A_CTL, 8'h40, 8'h40);
         wirq;
         chk(nss - n0, 32'h1);
         if (s < 7) clr;
      end
      n0 = nss;
      wr(A_TRG, 8'h00);
      repeat (40) @(posedge aclk);
      chk(nss - n0, 32'h0);
      clr;
      trig_flags <= 7'h00;
      wr(A_CTL, 8'h88);
      n0 = nss;
      wr(A_TRG, 8'h02);
      trig_flags <= 7'h02;
      repeat (40) @(posedge aclk);
      chk(nss - n0, 32'h0);
      $display("test 4 done");
      report_and_stop;
   end
endmodule // tb_top
bind adrtc_top adrtc_sva adrtc_sva_i (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .global_irq_enable(global_irq_enable), .irq_ack(irq_ack), .irq(irq),
   .sample_start(sample_start), .converter_on(converter_on));
`default_nettype wire
